/* File: logic/lane_align_defines.vh */
// Constants for the lane receive alignment and status block
// Behaviour
// [RL1] Idle mode selects PHY or inferred entry
// [RL2] Four lane route selectors reset to identity
// [RL3] Realign every ordered set, or after error
// [RL4] Mask training sets in L1/L23 when set
// [RL5] Recovery lock from LTSSM or PHY idle
// [RL6] Low-latency deskew fix enabled by bit
// [RL7] Per-lane hand-off buffer error flags 0-15
// [RL8] Per-lane deskew buffer error flags 16-31
// [RL9] Per-lane decode error flags bits 0-15
// [RL10] Per-lane disparity error flags bits 16-31
// [RL11] Read-only lane reversal status bit 2
// [RL12] Insert bits 16-21 corrupt lanes 0-5
// [RL13] Insert bits 22-31 corrupt lanes 6-15
// [RL14] Flags sticky; one symbol per insert arm
`ifndef LANE_ALIGN_DEFINES_VH
`define LANE_ALIGN_DEFINES_VH

// Register indexes; byte address is four times the index
`define IDX_PHY_CTRL        10'h040
`define IDX_BUF_FLAGS       10'h041
`define IDX_DEC_FLAGS       10'h042
`define IDX_DEBUG_INJECT    10'h043

// Control register fields and reset
`define CTRL_RESET          32'h32E4_0000
`define CTRL_WRITE_MASK     32'hFFFF_C000
`define IDLE_SEL_MSB        15
`define IDLE_SEL_LSB        14
`define ROUTE_LSB           16
`define GATING_MSB          27
`define GATING_LSB          24
`define REALIGN_BIT         28
`define MASK_TS_BIT         29
`define LOCK_SRC_BIT        30
`define LL_FIX_BIT          31

// Debug and inject register fields
`define REVERSAL_BIT        2
`define HW_DEBUG_MSB        15
`define HW_DEBUG_LSB        4
`define INSERT_LSB          16
`define DEBUG_WRITE_MASK    32'hFFFF_FFF0

// Idle detect modes
`define IDLE_MODE_MIXED     2'h0
`define IDLE_MODE_INFER     2'h1
`define IDLE_MODE_PHY       2'h2

// Invalid ten-bit symbol used for error insertion
`define INVALID_SYMBOL      10'b0001111001

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: logic/pcie_lane_rx_align_status.v */
// Lane receive alignment, error bookkeeping and error insertion with AXI4-Lite registers
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "lane_align_defines.vh"

module lane_stream_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// Fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_r;
	reg  [AW-1:0]    rd_ptr_r;
	reg  [AW:0]      count_r;
	wire             push;
	wire             pop;

	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	// Storage needs no reset; only the pointers and count define what is valid
	always @(posedge aclk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end
endmodule // lane_stream_fifo

module pcie_lane_rx_align_status (
	// Clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	// AXI4-Lite write address and data
	input  wire [11:0]   s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]    s_axi_bresp,
	output wire          s_axi_bvalid,
	input  wire          s_axi_bready,
	// AXI4-Lite read
	input  wire [11:0]   s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	output wire [31:0]   s_axi_rdata,
	output wire [1:0]    s_axi_rresp,
	output wire          s_axi_rvalid,
	input  wire          s_axi_rready,
	// Electrical idle handling
	input  wire          link_gen2,
	input  wire          phy_idle_entry,
	input  wire          inferred_idle_entry,
	input  wire          phy_idle_exit,
	output wire          idle_entry,
	output wire          idle_exit,
	// Receive lane stream through the crossbar
	input  wire [31:0]   rx_lane_data,
	input  wire          rx_lane_valid,
	output wire          rx_lane_ready,
	output wire [31:0]   rx_route_data,
	output wire          rx_route_valid,
	input  wire          rx_route_ready,
	output wire [3:0]    rx_enable_gating,
	// Lane deskew
	input  wire          ts_detect,
	input  wire          skp_detect,
	input  wire          deskew_error,
	input  wire          link_in_low_power,
	input  wire          low_latency_mode1,
	output wire          deskew_realign,
	output wire          deskew_fix_active,
	// Clock recovery lock
	input  wire          ltssm_lock_enable,
	input  wire          phy_rx_idle_async,
	output wire          recovery_lock_enable,
	// Per-lane error events and reversal status
	input  wire [15:0]   handoff_buf_err_lane,
	input  wire [15:0]   deskew_buf_err_lane,
	input  wire [15:0]   decode_err_lane,
	input  wire [15:0]   disparity_err_lane,
	input  wire          lane_reversed,
	// Transmit symbols with error insertion
	input  wire          tx_symbol_strobe,
	input  wire [159:0]  tx_symbol_in,
	output wire [159:0]  tx_symbol_out
);
	localparam SEL_NONE  = 3'd0;
	localparam SEL_CTRL  = 3'd1;
	localparam SEL_BUF   = 3'd2;
	localparam SEL_DEC   = 3'd3;
	localparam SEL_DEBUG = 3'd4;

	function [2:0] reg_decode;
		input [11:0] addr;
		begin
			if (addr[11:2] == `IDX_PHY_CTRL) begin
				reg_decode = SEL_CTRL;
			end else if (addr[11:2] == `IDX_BUF_FLAGS) begin
				reg_decode = SEL_BUF;
			end else if (addr[11:2] == `IDX_DEC_FLAGS) begin
				reg_decode = SEL_DEC;
			end else if (addr[11:2] == `IDX_DEBUG_INJECT) begin
				reg_decode = SEL_DEBUG;
			end else begin
				reg_decode = SEL_NONE;
			end
		end
	endfunction

	// Registers
	reg  [31:0]  ctrl_r;
	reg  [31:0]  buf_flags_r;
	reg  [31:0]  dec_flags_r;
	reg  [11:0]  hw_debug_field_r;
	reg  [15:0]  insert_arm_r;
	reg  [15:0]  insert_arm_nxt;
	reg  [159:0] tx_symbol_r;
	// Bus state
	reg  [11:0]  awaddr_r;
	reg          aw_got_r;
	reg  [31:0]  wdata_r;
	reg  [3:0]   wstrb_r;
	reg          w_got_r;
	reg          bvalid_r;
	reg  [1:0]   bresp_r;
	reg          rvalid_r;
	reg  [1:0]   rresp_r;
	reg  [31:0]  rdata_r;
	reg  [31:0]  rdata_nxt;
	// Block outputs
	reg          idle_entry_r;
	reg          idle_entry_nxt;
	reg          idle_exit_r;
	reg          realign_r;
	reg          err_pending_r;
	reg          fix_active_r;
	reg          lock_enable_r;

	wire         do_write;
	wire [2:0]   wr_sel;
	wire [2:0]   rd_sel;
	wire [31:0]  wmask;
	wire [31:0]  wbits;
	wire [31:0]  ctrl_wmask;
	wire [31:0]  debug_wmask;
	wire [15:0]  insert_fire;
	wire [159:0] tx_symbol_nxt;
	wire [31:0]  routed_data;
	wire         ts_effective;
	wire         ordered_set;
	wire [1:0]   idle_sel;

	// AXI4-Lite slave: address and data are taken in either order
	assign s_axi_awready = ~aw_got_r;
	assign s_axi_wready  = ~w_got_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	assign do_write    = aw_got_r & w_got_r & ~bvalid_r;
	assign wr_sel      = reg_decode(awaddr_r);
	assign rd_sel      = reg_decode(s_axi_araddr);
	assign wmask       = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wbits       = wdata_r & wmask;
	assign ctrl_wmask  = wmask & `CTRL_WRITE_MASK;
	assign debug_wmask = wmask & `DEBUG_WRITE_MASK;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 12'h000;
			aw_got_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			w_got_r  <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= `RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && !aw_got_r) begin
				awaddr_r <= s_axi_awaddr;
				aw_got_r <= 1'b1;
			end else if (do_write) begin
				aw_got_r <= 1'b0;
			end
			if (s_axi_wvalid && !w_got_r) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_got_r <= 1'b1;
			end else if (do_write) begin
				w_got_r <= 1'b0;
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r  <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (s_axi_arvalid && !rvalid_r) begin
				rvalid_r <= 1'b1;
				rresp_r  <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
				rdata_r  <= rdata_nxt;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	always @* begin
		if (rd_sel == SEL_CTRL) begin
			rdata_nxt = ctrl_r;
		end else if (rd_sel == SEL_BUF) begin
			rdata_nxt = buf_flags_r;
		end else if (rd_sel == SEL_DEC) begin
			rdata_nxt = dec_flags_r;
		end else if (rd_sel == SEL_DEBUG) begin
			rdata_nxt = {insert_arm_r, hw_debug_field_r, 1'b0, lane_reversed, 2'b00}; // see [RL11]
		end else begin
			rdata_nxt = 32'h0000_0000;
		end
	end

	// Control, sticky flags and debug field
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r           <= `CTRL_RESET; // see [RL2]
			buf_flags_r      <= 32'h0000_0000;
			dec_flags_r      <= 32'h0000_0000;
			hw_debug_field_r <= 12'h000;
		end else begin
			if (do_write && wr_sel == SEL_CTRL) begin
				ctrl_r <= (ctrl_r & ~ctrl_wmask) | (wdata_r & ctrl_wmask);
			end
			// Write-one-to-clear; a new event in the clearing cycle still sets the bit
			buf_flags_r <= (buf_flags_r & ~((do_write && wr_sel == SEL_BUF) ? wbits : 32'h0000_0000))
				| {deskew_buf_err_lane, handoff_buf_err_lane}; // see [RL7] [RL8] [RL14]
			dec_flags_r <= (dec_flags_r & ~((do_write && wr_sel == SEL_DEC) ? wbits : 32'h0000_0000))
				| {disparity_err_lane, decode_err_lane}; // see [RL9] [RL10] [RL14]
			if (do_write && wr_sel == SEL_DEBUG) begin
				hw_debug_field_r <= (hw_debug_field_r & ~debug_wmask[`HW_DEBUG_MSB:`HW_DEBUG_LSB])
					| (wdata_r[`HW_DEBUG_MSB:`HW_DEBUG_LSB] & debug_wmask[`HW_DEBUG_MSB:`HW_DEBUG_LSB]);
			end
		end
	end

	// Error insertion: an armed lane replaces its next symbol, then disarms itself
	assign insert_fire = insert_arm_r & {16{tx_symbol_strobe}};

	always @* begin
		insert_arm_nxt = insert_arm_r & ~insert_fire; // see [RL14]
		if (do_write && wr_sel == SEL_DEBUG) begin
			insert_arm_nxt = (insert_arm_nxt & ~debug_wmask[31:`INSERT_LSB])
				| (wdata_r[31:`INSERT_LSB] & debug_wmask[31:`INSERT_LSB]);
		end
	end

	genvar g;
	generate
		// Lanes only build the next word; one process owns the whole symbol register
		for (g = 0; g < 16; g = g + 1) begin : g_tx_lane
			assign tx_symbol_nxt[g*10 +: 10] = insert_fire[g] ? `INVALID_SYMBOL
				: tx_symbol_in[g*10 +: 10]; // see [RL12] [RL13]
		end
		// Receive crossbar: output byte i takes the lane its selector names
		for (g = 0; g < 4; g = g + 1) begin : g_route
			assign routed_data[g*8 +: 8] =
				rx_lane_data[ctrl_r[`ROUTE_LSB + 2*g +: 2]*8 +: 8]; // see [RL2]
		end
	endgenerate

	assign tx_symbol_out = tx_symbol_r;

	lane_stream_fifo #(
		.WIDTH (32),
		.DEPTH (8),
		.AW    (3)
	) u_route_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (routed_data),
		.in_valid  (rx_lane_valid),
		.in_ready  (rx_lane_ready),
		.out_data  (rx_route_data),
		.out_valid (rx_route_valid),
		.out_ready (rx_route_ready)
	);

	assign rx_enable_gating = ctrl_r[`GATING_MSB:`GATING_LSB];

	// Idle entry source; the reserved code behaves as PHY-driven
	assign idle_sel = ctrl_r[`IDLE_SEL_MSB:`IDLE_SEL_LSB];

	always @* begin
		case (idle_sel)
			`IDLE_MODE_MIXED: idle_entry_nxt = link_gen2 ? inferred_idle_entry : phy_idle_entry;
			`IDLE_MODE_INFER: idle_entry_nxt = inferred_idle_entry;
			default:          idle_entry_nxt = phy_idle_entry;
		endcase
	end

	// Deskew policy
	assign ts_effective = ts_detect & ~(ctrl_r[`MASK_TS_BIT] & link_in_low_power); // see [RL4]
	assign ordered_set  = ts_effective | skp_detect;

	always @(posedge aclk) begin
		if (!aresetn) begin
			idle_entry_r  <= 1'b0;
			idle_exit_r   <= 1'b0;
			realign_r     <= 1'b0;
			err_pending_r <= 1'b0;
			fix_active_r  <= 1'b0;
			lock_enable_r <= 1'b0;
		end else begin
			idle_entry_r  <= idle_entry_nxt; // see [RL1]
			idle_exit_r   <= phy_idle_exit;  // see [RL1]
			realign_r     <= ordered_set & (ctrl_r[`REALIGN_BIT] | err_pending_r); // see [RL3]
			// An error seen with an ordered set in the same cycle waits for the next one
			err_pending_r <= deskew_error | (err_pending_r & ~ordered_set); // see [RL3]
			fix_active_r  <= ctrl_r[`LL_FIX_BIT] & low_latency_mode1; // see [RL6]
			lock_enable_r <= ctrl_r[`LOCK_SRC_BIT] ? ~phy_rx_idle_async : ltssm_lock_enable; // see [RL5]
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			insert_arm_r <= 16'h0000;
			tx_symbol_r  <= {160{1'b0}};
		end else begin
			insert_arm_r <= insert_arm_nxt;
			tx_symbol_r  <= tx_symbol_nxt;
		end
	end

	assign idle_entry           = idle_entry_r;
	assign idle_exit            = idle_exit_r;
	assign deskew_realign       = realign_r;
	assign deskew_fix_active    = fix_active_r;
	assign recovery_lock_enable = lock_enable_r;
endmodule // pcie_lane_rx_align_status

/* File: bench/lane_sink.sv */
// Far-side receiver of the routed lane stream
`timescale 1ns/1ps
module lane_sink (
	// Clock and reset
	input logic	aclk,
	input logic	aresetn,
	// Routed stream
	input logic [31:0]	data,
	input logic	valid,
	output logic	ready,
	// Bench control
	input logic	stall
);
	logic [31:0]	got [0:15];
	int	n;
	// Slow on purpose: takes a word at most every other cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			ready <= 1'b0;
			n <= 0;
		end else begin
			ready <= !stall && !ready;
			if (valid && ready) begin
				got[n[3:0]] <= data;
				n <= n + 1;
			end
		end
	end
endmodule // lane_sink

/* File: bench/lane_align_sva.sv */
// Port checks for the lane alignment block
`timescale 1ns/1ps
module lane_align_sva (
	// Clock and reset
	input logic         aclk,
	input logic         aresetn,
	// Bus answers
	input logic         s_axi_bvalid,
	input logic         s_axi_bready,
	input logic         s_axi_rvalid,
	input logic         s_axi_rready,
	input logic [31:0]  s_axi_rdata,
	// Routed stream
	input logic [31:0]  rx_route_data,
	input logic         rx_route_valid,
	input logic         rx_route_ready,
	// Idle, lock and deskew
	input logic         phy_idle_entry,
	input logic         inferred_idle_entry,
	input logic         idle_entry,
	input logic         phy_idle_exit,
	input logic         idle_exit,
	input logic         ltssm_lock_enable,
	input logic         phy_rx_idle_async,
	input logic         recovery_lock_enable,
	input logic         low_latency_mode1,
	input logic         deskew_fix_active,
	// Transmit symbols
	input logic         tx_symbol_strobe,
	input logic [159:0] tx_symbol_in,
	input logic [159:0] tx_symbol_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Answers must stand until taken
	sequence b_held; s_axi_bvalid && !s_axi_bready; endsequence
	sequence r_held; s_axi_rvalid && !s_axi_rready; endsequence
	sequence head_held; rx_route_valid && !rx_route_ready; endsequence
	// Both entry sources agree, so the mode cannot matter
	sequence same_idle; phy_idle_entry == inferred_idle_entry; endsequence
	exit_follow_a: assert property (1'b1 |=> idle_exit == $past(phy_idle_exit))
		else $error("idle exit lag");
	entry_agree_a: assert property (same_idle |=> idle_entry == $past(phy_idle_entry))
		else $error("idle entry wrong");
	lock_source_a: assert property (ltssm_lock_enable != phy_rx_idle_async
		|=> recovery_lock_enable == $past(ltssm_lock_enable))
		else $error("lock enable wrong");
	fix_gate_a: assert property (!low_latency_mode1 |-> ##1 !deskew_fix_active)
		else $error("fix active without mode");
	tx_pass_a: assert property (!tx_symbol_strobe |=> tx_symbol_out == $past(tx_symbol_in))
		else $error("symbol altered");
	head_hold_a: assert property (head_held |=> rx_route_valid && $stable(rx_route_data))
		else $error("stream head dropped");
	read_hold_a: assert property (r_held |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	clear_resp_a: assert property (b_held |=> s_axi_bvalid)
		else $error("write answer dropped");
endmodule // lane_align_sva
bind pcie_lane_rx_align_status lane_align_sva chk_u (
	.aclk                 (aclk),
	.aresetn              (aresetn),
	.s_axi_bvalid         (s_axi_bvalid),
	.s_axi_bready         (s_axi_bready),
	.s_axi_rvalid         (s_axi_rvalid),
	.s_axi_rready         (s_axi_rready),
	.s_axi_rdata          (s_axi_rdata),
	.rx_route_data        (rx_route_data),
	.rx_route_valid       (rx_route_valid),
	.rx_route_ready       (rx_route_ready),
	.phy_idle_entry       (phy_idle_entry),
	.inferred_idle_entry  (inferred_idle_entry),
	.idle_entry           (idle_entry),
	.phy_idle_exit        (phy_idle_exit),
	.idle_exit            (idle_exit),
	.ltssm_lock_enable    (ltssm_lock_enable),
	.phy_rx_idle_async    (phy_rx_idle_async),
	.recovery_lock_enable (recovery_lock_enable),
	.low_latency_mode1    (low_latency_mode1),
	.deskew_fix_active    (deskew_fix_active),
	.tx_symbol_strobe     (tx_symbol_strobe),
	.tx_symbol_in         (tx_symbol_in),
	.tx_symbol_out        (tx_symbol_out)
);

/* File: bench/testbench.sv */
// Self-checking bench for the lane alignment block
`timescale 1ns/1ps
`include "lane_align_defines.vh"
module testbench;
	logic	aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic	s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic	s_axi_rvalid, link_gen2, phy_idle_entry, inferred_idle_entry, phy_idle_exit;
	logic	idle_entry, idle_exit, rx_lane_valid, rx_lane_ready, rx_route_valid;
	logic	rx_route_ready, stall, ts_detect, skp_detect, deskew_error, link_in_low_power;
	logic	low_latency_mode1, deskew_realign, deskew_fix_active, ltssm_lock_enable;
	logic	phy_rx_idle_async, recovery_lock_enable, lane_reversed, tx_symbol_strobe;
	logic [11:0]	s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, s_axi_rdata, rx_lane_data, rx_route_data, rdat;
	logic [3:0]	s_axi_wstrb, rx_enable_gating;
	logic [1:0]	s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0]	handoff_buf_err_lane, deskew_buf_err_lane, decode_err_lane, disparity_err_lane;
	logic [159:0]	tx_symbol_in, tx_symbol_out;
	int	err_count, checks_done, cyc, i;

	pcie_lane_rx_align_status dut_u (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_axi_awaddr         (s_axi_awaddr),
		.s_axi_awvalid        (s_axi_awvalid),
		.s_axi_awready        (s_axi_awready),
		.s_axi_wdata          (s_axi_wdata),
		.s_axi_wstrb          (s_axi_wstrb),
		.s_axi_wvalid         (s_axi_wvalid),
		.s_axi_wready         (s_axi_wready),
		.s_axi_bresp          (s_axi_bresp),
		.s_axi_bvalid         (s_axi_bvalid),
		.s_axi_bready         (s_axi_bready),
		.s_axi_araddr         (s_axi_araddr),
		.s_axi_arvalid        (s_axi_arvalid),
		.s_axi_arready        (s_axi_arready),
		.s_axi_rdata          (s_axi_rdata),
		.s_axi_rresp          (s_axi_rresp),
		.s_axi_rvalid         (s_axi_rvalid),
		.s_axi_rready         (s_axi_rready),
		.link_gen2            (link_gen2),
		.phy_idle_entry       (phy_idle_entry),
		.inferred_idle_entry  (inferred_idle_entry),
		.phy_idle_exit        (phy_idle_exit),
		.idle_entry           (idle_entry),
		.idle_exit            (idle_exit),
		.rx_lane_data         (rx_lane_data),
		.rx_lane_valid        (rx_lane_valid),
		.rx_lane_ready        (rx_lane_ready),
		.rx_route_data        (rx_route_data),
		.rx_route_valid       (rx_route_valid),
		.rx_route_ready       (rx_route_ready),
		.rx_enable_gating     (rx_enable_gating),
		.ts_detect            (ts_detect),
		.skp_detect           (skp_detect),
		.deskew_error         (deskew_error),
		.link_in_low_power    (link_in_low_power),
		.low_latency_mode1    (low_latency_mode1),
		.deskew_realign       (deskew_realign),
		.deskew_fix_active    (deskew_fix_active),
		.ltssm_lock_enable    (ltssm_lock_enable),
		.phy_rx_idle_async    (phy_rx_idle_async),
		.recovery_lock_enable (recovery_lock_enable),
		.handoff_buf_err_lane (handoff_buf_err_lane),
		.deskew_buf_err_lane  (deskew_buf_err_lane),
		.decode_err_lane      (decode_err_lane),
		.disparity_err_lane   (disparity_err_lane),
		.lane_reversed        (lane_reversed),
		.tx_symbol_strobe     (tx_symbol_strobe),
		.tx_symbol_in         (tx_symbol_in),
		.tx_symbol_out        (tx_symbol_out)
	);
	lane_sink snk_u (.aclk(aclk), .aresetn(aresetn), .data(rx_route_data),
		.valid(rx_route_valid), .ready(rx_route_ready), .stall(stall));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task summarize;
		$display("mismatches %0d of %0d checks", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				rsp = s_axi_bresp;
			end
		end while (s_axi_bready);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				rdat = s_axi_rdata;
				rsp = s_axi_rresp;
			end
		end while (s_axi_rready);
		chk(rdat, exp);
	endtask

	task t_idle;
		for (int m = 0; m < 4; m++)
			for (int g = 0; g < 2; g++) begin
				wr(12'h100, 32'h32E4_0000 | (m << 14));
				link_gen2 <= g[0];
				repeat (2) @(posedge aclk);
				chk(idle_entry, m >= 2 || (m == 0 && g == 0));
			end
		// Both entry sources high: the reserved mode left by the loop reports entry; exit follows the PHY alone
		{inferred_idle_entry, phy_idle_exit} <= 2'b11;
		repeat (2) @(posedge aclk);
		chk(idle_entry, 1);
		chk(idle_exit, 1);
		{inferred_idle_entry, phy_idle_exit} <= 2'b00;
	endtask

	task t_flags;
		{handoff_buf_err_lane, deskew_buf_err_lane} <= 32'h0001_8000;
		{decode_err_lane, disparity_err_lane} <= 32'h0008_4000;
		@(posedge aclk);
		{handoff_buf_err_lane, deskew_buf_err_lane, decode_err_lane, disparity_err_lane} <= '0;
		repeat (4) @(posedge aclk);
		rd(12'h104, 32'h8000_0001);
		rd(12'h108, 32'h4000_0008);
		wr(12'h104, 32'h8000_0000);
		rd(12'h104, 32'h0000_0001);
		// Only the top byte lane is written, so only the disparity flag clears
		s_axi_wstrb <= 4'h8;
		wr(12'h108, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'hF;
		rd(12'h108, 32'h0000_0008);
		wr(12'h108, 32'hFFFF_FFFF);
		rd(12'h108, 32'h0000_0000);
	endtask

	task os(input logic s, input logic t, input logic e, input logic x);
		{skp_detect, ts_detect, deskew_error} <= {s, t, e};
		@(posedge aclk);
		{skp_detect, ts_detect, deskew_error} <= 3'b000;
		@(posedge aclk);
		chk(deskew_realign, x);
	endtask

	task t_deskew;
		os(1, 0, 0, 1);
		link_in_low_power <= 1'b1;
		os(0, 1, 0, 0);
		link_in_low_power <= 1'b0;
		os(0, 1, 0, 1);
		wr(12'h100, 32'h22E4_0000);
		os(1, 0, 0, 0);
		os(0, 0, 1, 0);
		os(1, 0, 0, 1);
		os(1, 0, 0, 0);
	endtask

	task t_ctrl;
		wr(12'h100, 32'hF2E4_3FFF);
		rd(12'h100, 32'hF2E4_0000);
		low_latency_mode1 <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(recovery_lock_enable, 1);
		chk(deskew_fix_active, 1);
		wr(12'h100, 32'h32E4_0000);
		repeat (2) @(posedge aclk);
		chk(recovery_lock_enable, 0);
		chk(deskew_fix_active, 0);
		ltssm_lock_enable <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(recovery_lock_enable, 1);
	endtask

	task strobe;
		tx_symbol_strobe <= 1'b1;
		@(posedge aclk);
		tx_symbol_strobe <= 1'b0;
		@(posedge aclk);
	endtask

	task t_insert;
		lane_reversed <= 1'b1;
		tx_symbol_in <= {16{10'h2AA}};
		wr(12'h10C, 32'h8041_ABC0);
		rd(12'h10C, 32'h8041_ABC4);
		strobe;
		chk(tx_symbol_out[9:0], `INVALID_SYMBOL);
		chk(tx_symbol_out[19:10], 10'h2AA);
		chk(tx_symbol_out[69:60], `INVALID_SYMBOL);
		chk(tx_symbol_out[159:150], `INVALID_SYMBOL);
		strobe;
		chk(tx_symbol_out[9:0], 10'h2AA);
		rd(12'h10C, 32'h0000_ABC4);
	endtask

	task push(input int n);
		while (i < n) begin
			@(posedge aclk);
			if (rx_lane_ready) begin
				i++;
				rx_lane_data <= 32'hD0C0_B0A0 + i;
			end
		end
	endtask

	// Crossbar reversed; the ninth word must wait for the stalled sink
	task t_stream;
		wr(12'h100, 32'h321B_0000);
		stall <= 1'b1;
		rx_lane_data <= 32'hD0C0_B0A0;
		rx_lane_valid <= 1'b1;
		push(8);
		repeat (3) @(posedge aclk);
		chk(rx_lane_ready, 0);
		stall <= 1'b0;
		push(9);
		rx_lane_valid <= 1'b0;
		while (snk_u.n < 9) @(posedge aclk);
		chk(rx_route_valid, 0);
		for (int k = 0; k < 9; k++)
			chk(snk_u.got[k], 32'hA0B0_C0D0 + (k << 24));
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_lane_data, tx_symbol_in} = '0;
		{link_gen2, inferred_idle_entry, phy_idle_exit, rx_lane_valid, stall} = '0;
		{ts_detect, skp_detect, deskew_error, link_in_low_power, low_latency_mode1} = '0;
		{ltssm_lock_enable, phy_rx_idle_async, lane_reversed, tx_symbol_strobe} = '0;
		{handoff_buf_err_lane, deskew_buf_err_lane, decode_err_lane, disparity_err_lane} = '0;
		phy_idle_entry = 1'b1;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h100, 32'h32E4_0000);
		rd(12'h10C, 32'h0000_0000);
		chk(rx_enable_gating, 2);
		rd(12'h200, 32'h0000_0000);
		chk(rsp, 2);
		wr(12'h200, 32'hFFFF_FFFF);
		chk(rsp, 2);
		t_idle;
		t_flags;
		t_deskew;
		t_ctrl;
		t_insert;
		t_stream;
		summarize;
	end
endmodule // testbench
